// ---- include/e3_ovh_pkg.sv ----
// shared constants and types for the e3 g.832 transmit overhead inserter
package e3_ovh_pkg;

  // frame geometry: 537 octets, bits counted msb first within each octet
  localparam logic [12:0] POS_LAST   = 13'h10c7;  // last bit of a frame
  localparam logic [9:0]  OCT_FA1    = 10'h000;   // first alignment octet
  localparam logic [9:0]  OCT_FA2    = 10'h001;   // second alignment octet
  localparam logic [9:0]  OCT_EM     = 10'h03c;   // error monitoring octet
  localparam logic [9:0]  OCT_TR     = 10'h077;   // trail trace octet
  localparam logic [9:0]  OCT_MA     = 10'h0b2;   // maintenance octet
  localparam logic [9:0]  OCT_NR     = 10'h0ed;   // network operator octet
  localparam logic [9:0]  OCT_GC     = 10'h128;   // general channel octet

  // fixed alignment patterns
  localparam logic [7:0]  FA1_PATTERN = 8'hf6;    // 11110110
  localparam logic [7:0]  FA2_PATTERN = 8'h28;    // 00101000

  // bit positions inside the maintenance octet, sent first = 0
  localparam logic [2:0]  MA_RDI     = 3'h0;
  localparam logic [2:0]  MA_REI     = 3'h1;
  localparam logic [2:0]  MA_PD_HI   = 3'h5;
  localparam logic [2:0]  MA_PD_LO   = 3'h6;

  // register byte offsets
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_FIELD  = 4'h4;
  localparam logic [3:0]  REG_STATUS = 4'h8;
  localparam logic [3:0]  REG_FRAMES = 4'hc;

  // control register layout, bit 0 is ovh_with_data_sel
  typedef struct packed {
    logic [1:0] alarm_ctrl;            // [12:11] upper forces rdi, lower ais
    logic [2:0] data_link_mode;        // [10:8]
    logic       status_msg_mode_en;    // [7]
    logic       pd_mi_src_sel;         // [6]
    logic       ext_err_just_sel;      // [5]
    logic       ext_remote_alarm_sel;  // [4]
    logic       auto_remote_alarm_en;  // [3]
    logic       trail_trace_src_sel;   // [2]
    logic       ext_align_sel;         // [1]
    logic       ovh_with_data_sel;     // [0]
  } ctrl_t;

  // field register layout
  typedef struct packed {
    logic [3:0] status_msg_field;      // [8:5] msb is first message bit/tm
    logic [1:0] payload_dep_field;     // [4:3]
    logic [2:0] payload_type_field;    // [2:0] msb sent first
  } field_t;

  localparam logic [12:0] CTRL_RST  = 13'h0000;
  localparam logic [8:0]  FIELD_RST = 9'h000;

  // sources of the nr and gc octets
  typedef enum logic [1:0] {DL_ONES, DL_EXT, DL_LAPD} dl_src_t;

endpackage : e3_ovh_pkg

// ---- hw/e3_g832_tx_overhead_insert.sv ----
// e3 g.832 transmit overhead inserter with avalon-mm register slave
//
// How it works
// RL1: frame carries seven overhead octets
// RL2: data-stream control sources all or no overhead
// RL3: insert fixed alignment octets unless external
// RL4: even bip-8 of previous frame into em
// RL5: trail trace from pin, else all zeros
// RL6: auto rdi follows receive los or oof
// RL7: manual mode rdi from pin, else zero
// RL8: upper alarm bit forces rdi to one
// RL9: rei from pin or generated automatically
// RL10: receive bip mismatch sends rei one frame
// RL11: payload type field, new value next frame
// RL12: status mode: mi internal or from pin
// RL13: mi two-bit counter, cleared on auto enable
// RL14: no status mode: pd from pin or field
// RL15: bit 8 timing marker or selected message bit
// RL16: three-bit mode picks eight nr/gc combinations
// RL17: only one lapd link active at once
// RL18: nr/gc from pin, lapd, or all ones
// RL19: software sets and clears alarm controls
// RL20: alarm controls leave system interface untouched
// RL21: receive indications synchronised before use
`timescale 1ns/1ps
module e3_g832_tx_overhead_insert #(
  parameter int BIT_DIV = 8              // clk cycles per line bit, >= 4
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // avalon-mm register slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // system data stream, same clock
  input  wire logic        sys_data_in,
  output logic             sys_data_req,
  // external overhead pin, asynchronous
  input  wire logic        ext_overhead_in,
  output logic             ext_ovh_req,
  // internal lapd data link bit source, same clock
  input  wire logic        dl_link_in,
  output logic             dl_link_req,
  // receive side indications, asynchronous
  input  wire logic        rx_los,
  input  wire logic        rx_oof,
  input  wire logic        rx_bip_err_tgl,
  // line side
  output logic             line_data,
  output logic             line_bit_en,
  output logic             line_frame_start
);

  // reset release and input synchronisers
  logic       rst_s1_q;                  // first reset release stage
  logic       rst_s2_q;                  // reset used by everything else
  logic [3:0] sync1_q;                   // first stage, read only by sync2
  logic [3:0] sync2_q;                   // synchronised copies
  logic       bip_tgl_d_q;               // previous synced toggle level
  logic       los_s;                     // synced loss_of_signal
  logic       oof_s;                     // synced out_of_frame
  logic       ext_s;                     // synced ext_overhead_in
  logic       bip_err_evt;               // one pulse per receive mismatch

  // assert at once, release two edges later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // two flops on every asynchronous input
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      sync1_q     <= 4'h0;
      sync2_q     <= 4'h0;
      bip_tgl_d_q <= 1'b0;
    end else begin
      sync1_q     <= {rx_bip_err_tgl, ext_overhead_in, rx_oof, rx_los}; // RL21
      sync2_q     <= sync1_q;                                          // RL21
      bip_tgl_d_q <= sync2_q[3];
    end
  end

  assign los_s       = sync2_q[0];
  assign oof_s       = sync2_q[1];
  assign ext_s       = sync2_q[2];
  // a toggle carries events safely across; edge taken after stage two
  assign bip_err_evt = sync2_q[3] ^ bip_tgl_d_q;                     // RL21

  // register file
  e3_ovh_pkg::ctrl_t  ctrl_q;            // control register
  e3_ovh_pkg::field_t field_q;           // field register
  logic        ack_q;                    // second cycle of an access
  logic [31:0] rdata_q;                  // captured read answer
  logic [31:0] rd_mux;                   // read selection
  logic [31:0] be_mask;                  // byte lane mask
  logic [31:0] ctrl_wr;                  // merged ctrl write value
  logic [31:0] field_wr;                 // merged field write value
  logic [31:0] status_word;              // live status
  logic        wr_take;                  // write completes this edge
  logic        hit_ctrl;
  logic        hit_field;
  logic        hit_status;
  logic        hit_frames;
  logic [15:0] frame_cnt_q;              // frames sent since reset
  logic [7:0]  bip_prev_q;               // bip-8 of the previous frame
  logic [1:0]  mi_cnt_q;                 // multiframe counter
  logic        rei_pend_q;               // rei waiting to be sent
  logic        rdi_bit;                  // current rdi value

  // one wait state: request captured, then answered on the next edge
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_take     = write & ack_q;

  // address decode
  assign hit_ctrl   = (address == e3_ovh_pkg::REG_CTRL);
  assign hit_field  = (address == e3_ovh_pkg::REG_FIELD);
  assign hit_status = (address == e3_ovh_pkg::REG_STATUS);
  assign hit_frames = (address == e3_ovh_pkg::REG_FRAMES);

  assign be_mask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign ctrl_wr  = (writedata & be_mask) |
                    ({19'h00000, ctrl_q} & ~be_mask);
  assign field_wr = (writedata & be_mask) |
                    ({23'h000000, field_q} & ~be_mask);

  // status shows the block's own state
  assign status_word = {16'h0000, bip_prev_q, 2'h0, mi_cnt_q,
                        rei_pend_q, rdi_bit, oof_s, los_s};

  // unmapped offsets read zero and ignore writes
  assign rd_mux = hit_ctrl   ? {19'h00000, ctrl_q}   :
                  hit_field  ? {23'h000000, field_q} :
                  hit_status ? status_word           :
                  hit_frames ? {16'h0000, frame_cnt_q} :
                  32'h00000000;

  // handshake and read capture
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= (read | write) & ~ack_q;
      if (read && !ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign readdata = rdata_q;

  // writable registers; alarms hold until software clears them
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      ctrl_q  <= e3_ovh_pkg::ctrl_t'(e3_ovh_pkg::CTRL_RST);
      field_q <= e3_ovh_pkg::field_t'(e3_ovh_pkg::FIELD_RST);
    end else if (wr_take && hit_ctrl) begin
      ctrl_q  <= e3_ovh_pkg::ctrl_t'(ctrl_wr[12:0]);                  // RL19
    end else if (wr_take && hit_field) begin
      field_q <= e3_ovh_pkg::field_t'(field_wr[8:0]);
    end
  end

  // bit rate enable and frame position
  logic [7:0]  div_q;                    // bit period divider
  logic        bit_en;                   // one pulse per line bit
  logic [12:0] pos_q;                    // bit being produced next
  logic [9:0]  octet;                    // octet index of pos_q
  logic [2:0]  bidx;                     // bit within octet, 0 sent first
  logic [2:0]  bsel;                     // vector index of that bit
  logic        frame_end;                // last bit of the frame

  assign bit_en    = (div_q == 8'(BIT_DIV - 1));
  assign octet     = pos_q[12:3];
  assign bidx      = pos_q[2:0];
  assign bsel      = 3'h7 - bidx;
  assign frame_end = (pos_q == e3_ovh_pkg::POS_LAST);

  // divider and position counter
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      div_q <= 8'h00;
      pos_q <= 13'h0000;
    end else begin
      div_q <= bit_en ? 8'h00 : div_q + 8'h01;
      if (bit_en) begin
        pos_q <= frame_end ? 13'h0000 : pos_q + 13'h0001;
      end
    end
  end

  // overhead slot decode
  logic is_fa1, is_fa2, is_em, is_tr, is_ma, is_nr, is_gc;
  logic is_ovh;                          // any overhead octet
  logic ovh_int;                         // overhead not taken from data

  assign is_fa1  = (octet == e3_ovh_pkg::OCT_FA1);
  assign is_fa2  = (octet == e3_ovh_pkg::OCT_FA2);
  assign is_em   = (octet == e3_ovh_pkg::OCT_EM);
  assign is_tr   = (octet == e3_ovh_pkg::OCT_TR);
  assign is_ma   = (octet == e3_ovh_pkg::OCT_MA);
  assign is_nr   = (octet == e3_ovh_pkg::OCT_NR);
  assign is_gc   = (octet == e3_ovh_pkg::OCT_GC);
  // seven overhead octets per frame
  assign is_ovh  = is_fa1 | is_fa2 | is_em | is_tr |
                   is_ma | is_nr | is_gc;                            // RL1
  assign ovh_int = is_ovh & ~ctrl_q.ovh_with_data_sel;               // RL2

  // nr and gc sources
  e3_ovh_pkg::dl_src_t nr_src;           // network operator source
  e3_ovh_pkg::dl_src_t gc_src;           // general channel source
  e3_ovh_pkg::dl_src_t dl_src;           // source of the current octet
  logic [2:0] dlm;
  logic       dl_bit;

  assign dlm = ctrl_q.data_link_mode;
  // the encoding never gives lapd to both octets at once
  assign nr_src = dlm[2] ? (dlm[1] ? (dlm[0] ? e3_ovh_pkg::DL_EXT
                                             : e3_ovh_pkg::DL_ONES)
                                   : e3_ovh_pkg::DL_LAPD)
                         : (dlm[0] ? e3_ovh_pkg::DL_EXT
                                   : e3_ovh_pkg::DL_ONES);           // RL16
  assign gc_src = dlm[2] ? (dlm[1] ? e3_ovh_pkg::DL_LAPD
                                   : (dlm[0] ? e3_ovh_pkg::DL_EXT
                                             : e3_ovh_pkg::DL_ONES))
                         : (dlm[1] ? e3_ovh_pkg::DL_EXT
                                   : e3_ovh_pkg::DL_ONES);           // RL17
  assign dl_src = is_nr ? nr_src : gc_src;
  assign dl_bit = (dl_src == e3_ovh_pkg::DL_EXT)  ? ext_s      :
                  (dl_src == e3_ovh_pkg::DL_LAPD) ? dl_link_in :
                  1'b1;                                              // RL18

  // maintenance octet
  logic [2:0] pt_frame_q;                // payload type held per frame
  logic [1:0] mi_sent_q;                 // mi bits actually sent
  logic       auto_mi;                   // internal mi generation on
  logic       auto_mi_d_q;               // previous auto_mi
  logic       rei_bit;
  logic       pd_hi, pd_lo;              // bits 6 and 7
  logic [1:0] ssm_i;                     // message bit index
  logic       tm_bit;                    // bit 8
  logic [7:0] ma_byte;

  // forced alarm wins, then auto, then pin, else zero
  assign rdi_bit = ctrl_q.alarm_ctrl[1] ? 1'b1 :                     // RL8
                   ctrl_q.auto_remote_alarm_en ? (los_s | oof_s) :   // RL6
                   ctrl_q.ext_remote_alarm_sel ? ext_s : 1'b0;       // RL7
  assign rei_bit = ctrl_q.ext_err_just_sel ? ext_s : rei_pend_q;     // RL9
  assign auto_mi = ctrl_q.status_msg_mode_en & ~ctrl_q.pd_mi_src_sel;
  // pin select wins, then status mode uses the counter, otherwise the register field
  assign pd_hi = ctrl_q.pd_mi_src_sel ? ext_s :
                 ctrl_q.status_msg_mode_en ? mi_cnt_q[1] :
                 field_q.payload_dep_field[1];                       // RL12
  assign pd_lo = ctrl_q.pd_mi_src_sel ? ext_s :
                 ctrl_q.status_msg_mode_en ? mi_cnt_q[0] :
                 field_q.payload_dep_field[0];                       // RL14
  assign ssm_i  = 2'h3 - mi_sent_q;
  assign tm_bit = ctrl_q.status_msg_mode_en ?
                  field_q.status_msg_field[ssm_i] :
                  field_q.status_msg_field[3];                       // RL15
  assign ma_byte = {rdi_bit, rei_bit, pt_frame_q, pd_hi, pd_lo, tm_bit}; // RL11

  // bit selection
  logic ovh_bit;                         // internally chosen overhead bit
  logic tx_bit;                          // framed bit before ais
  logic ma_ext;                          // this ma bit comes from the pin

  assign ma_ext = (bidx == e3_ovh_pkg::MA_RDI) ?
                    (~ctrl_q.alarm_ctrl[1] & ~ctrl_q.auto_remote_alarm_en &
                     ctrl_q.ext_remote_alarm_sel) :
                  (bidx == e3_ovh_pkg::MA_REI) ? ctrl_q.ext_err_just_sel :
                  (bidx == e3_ovh_pkg::MA_PD_HI ||
                   bidx == e3_ovh_pkg::MA_PD_LO) ? ctrl_q.pd_mi_src_sel :
                  1'b0;

  assign ovh_bit =
    (is_fa1 || is_fa2) ? (ctrl_q.ext_align_sel ? ext_s :
                          is_fa1 ? e3_ovh_pkg::FA1_PATTERN[bsel] :
                                   e3_ovh_pkg::FA2_PATTERN[bsel]) :  // RL3
    is_em ? bip_prev_q[bsel] :                                       // RL4
    is_tr ? (ctrl_q.trail_trace_src_sel & ext_s) :                   // RL5
    is_ma ? ma_byte[bsel] :
    dl_bit;

  assign tx_bit = ovh_int ? ovh_bit : sys_data_in;                   // RL2

  // requests to the neighbours; only ext_ovh_req depends on alarm_ctrl, through the rdi bit
  assign sys_data_req = bit_en & ~ovh_int;                           // RL20
  assign ext_ovh_req  = ovh_int &
                        (((is_fa1 | is_fa2) & ctrl_q.ext_align_sel) |
                         (is_tr & ctrl_q.trail_trace_src_sel) |
                         (is_ma & ma_ext) |
                         ((is_nr | is_gc) &
                          (dl_src == e3_ovh_pkg::DL_EXT)));
  assign dl_link_req  = bit_en & ovh_int & (is_nr | is_gc) &
                        (dl_src == e3_ovh_pkg::DL_LAPD);             // RL17

  // bip-8 accumulation over every sent bit, overhead included
  logic [7:0] bip_acc_q;                 // parity of the current frame
  logic [7:0] bip_next;                  // accumulator with this bit

  assign bip_next = bip_acc_q ^ ((8'h80 >> bidx) & {8{tx_bit}});     // RL4

  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      bip_acc_q  <= 8'h00;
      bip_prev_q <= 8'h00;
    end else if (bit_en) begin
      bip_acc_q <= frame_end ? 8'h00 : bip_next;
      if (frame_end) begin
        bip_prev_q <= bip_next;                                      // RL4
      end
    end
  end

  // per-frame state: payload type, mi counter, frame count
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      pt_frame_q  <= 3'h0;
      mi_cnt_q    <= 2'h0;
      auto_mi_d_q <= 1'b0;
      frame_cnt_q <= 16'h0000;
    end else begin
      auto_mi_d_q <= auto_mi;
      // turning on automatic mi restarts the count
      if (auto_mi && !auto_mi_d_q) begin
        mi_cnt_q <= 2'h0;                                            // RL13
      end else if (bit_en && frame_end) begin
        mi_cnt_q <= mi_cnt_q + 2'h1;                                 // RL13
      end
      // payload type only changes on a frame boundary
      if (bit_en && frame_end) begin
        pt_frame_q  <= field_q.payload_type_field;                   // RL11
        frame_cnt_q <= frame_cnt_q + 16'h0001;
      end
    end
  end

  // rei pending: a new mismatch wins over the clear on send
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      rei_pend_q <= 1'b0;
    end else if (bit_en && ovh_int && is_ma &&
                 bidx == e3_ovh_pkg::MA_REI &&
                 !ctrl_q.ext_err_just_sel) begin
      rei_pend_q <= bip_err_evt;                                     // RL10
    end else if (bip_err_evt) begin
      rei_pend_q <= 1'b1;                                            // RL10
    end
  end

  // remember the mi value sent so bit 8 picks the matching message bit
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      mi_sent_q <= 2'h0;
    end else if (bit_en && is_ma && bidx == e3_ovh_pkg::MA_PD_HI) begin
      mi_sent_q[1] <= tx_bit;                                        // RL15
    end else if (bit_en && is_ma && bidx == e3_ovh_pkg::MA_PD_LO) begin
      mi_sent_q[0] <= tx_bit;                                        // RL15
    end
  end

  // line output; ais replaces the line with all ones at once
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      line_data        <= 1'b0;
      line_bit_en      <= 1'b0;
      line_frame_start <= 1'b0;
    end else begin
      line_bit_en      <= bit_en;
      line_frame_start <= bit_en & (pos_q == 13'h0000);
      if (bit_en) begin
        line_data <= ctrl_q.alarm_ctrl[0] | tx_bit;                  // RL20
      end
    end
  end

endmodule : e3_g832_tx_overhead_insert

// ---- test/ovh_insert_sva.sv ----
// port assertions for the e3 overhead inserter
`timescale 1ns/1ps
module ovh_insert_sva #(parameter int BIT_DIV = 8) (
  // clock, reset and bus handshake
  input wire logic clk, rst_b, read, write, waitrequest,
  // stream requests and line side
  input wire logic sys_data_req, ext_ovh_req, dl_link_req,
  input wire logic line_data, line_bit_en, line_frame_start
);
  logic [12:0] cnt_q;  // line bits since the last frame start
  logic        seen_q; // the first frame has no start before it
  // count line bits so the frame length can be measured
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 13'h0000;
    else if (line_frame_start) cnt_q <= 13'h0000;
    else if (line_bit_en) cnt_q <= cnt_q + 13'h0001;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) seen_q <= 1'b0;
    else if (line_frame_start) seen_q <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_frame_len: assert property (line_frame_start && seen_q |->
    cnt_q == e3_ovh_pkg::POS_LAST) else $error("frame length wrong");
  a_start_bit: assert property (line_frame_start |-> line_bit_en)
    else $error("frame start off a bit");
  a_bit_space: assert property (line_bit_en |-> ##BIT_DIV line_bit_en)
    else $error("bit period wrong");
  a_line_hold: assert property (!line_bit_en |-> $stable(line_data))
    else $error("line data moved between bits");
  a_sys_next: assert property (sys_data_req |=> line_bit_en)
    else $error("system bit not sent next");
  a_dl_next: assert property (dl_link_req |=> line_bit_en)
    else $error("link bit not sent next");
  a_one_src: assert property (!(sys_data_req && dl_link_req))
    else $error("two sources for one bit");
  a_ext_hold: assert property ($rose(ext_ovh_req) |-> ext_ovh_req [*3])
    else $error("pin request dropped early");
  a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait state count wrong");
endmodule : ovh_insert_sva
bind e3_g832_tx_overhead_insert ovh_insert_sva #(.BIT_DIV(BIT_DIV)) i_sva (
  .clk(clk), .rst_b(rst_b), .read(read), .write(write),
  .waitrequest(waitrequest), .sys_data_req(sys_data_req),
  .ext_ovh_req(ext_ovh_req), .dl_link_req(dl_link_req), .line_data(line_data),
  .line_bit_en(line_bit_en), .line_frame_start(line_frame_start));

// ---- test/ovh_far_model.sv ----
// system data and link bit source beside the inserter
`timescale 1ns/1ps
module ovh_far_model (
  // clock, requests and bench controls
  input  wire logic clk, sys_data_req, dl_link_req, sys_zero, ext_level,
  // bits handed to the inserter
  output logic      sys_data_in, dl_link_in, ext_overhead_in
);
  logic [7:0] s_q = 8'h35; // moves on every consumed bit, repeats show up
  // advance only when a bit is taken, as a real source would
  always @(posedge clk)
    if (sys_data_req || dl_link_req) s_q <= {s_q[6:0], ^(s_q & 8'hb8)};
  assign sys_data_in     = sys_zero ? 1'b0 : s_q[0];
  assign dl_link_in      = s_q[1];
  assign ext_overhead_in = ext_level; // pin held steady, it is resynced
endmodule : ovh_far_model

// ---- test/e3_g832_tx_overhead_insert_test.sv ----
// self-checking bench for the e3 overhead inserter
`timescale 1ns/1ps
module e3_g832_tx_overhead_insert_test;
  localparam int BD = 4;  // short bit period keeps five frames in budget
  logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, sys_data_in, sys_data_req, ext_overhead_in, ext_ovh_req;
  logic dl_link_in, dl_link_req, line_data, line_bit_en, line_frame_start;
  logic rx_los = 1'b0, rx_oof = 1'b0, rx_bip_err_tgl = 1'b0;
  logic sys_zero = 1'b0, ext_level = 1'b1;
  logic cur [4296], fp [4296], fr [4296] = '{default: 1'b0};
  logic [7:0] dbyte = 8'h00, dprev = 8'h00, lf = 8'h47;
  logic [1:0] mi;
  logic sq [$];  // system bits in the order they were taken
  int pos = 0, nf = 0, n_errors = 0, comparisons = 0, cyc = 0;
  always #25 clk = ~clk;
  e3_g832_tx_overhead_insert #(.BIT_DIV(BD)) i_dut (.clk(clk), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .sys_data_in(sys_data_in), .sys_data_req(sys_data_req),
    .ext_overhead_in(ext_overhead_in), .ext_ovh_req(ext_ovh_req),
    .dl_link_in(dl_link_in), .dl_link_req(dl_link_req), .rx_los(rx_los),
    .rx_oof(rx_oof), .rx_bip_err_tgl(rx_bip_err_tgl), .line_data(line_data),
    .line_bit_en(line_bit_en), .line_frame_start(line_frame_start));
  ovh_far_model i_far (.clk(clk), .sys_data_req(sys_data_req),
    .dl_link_req(dl_link_req), .sys_zero(sys_zero), .ext_level(ext_level),
    .sys_data_in(sys_data_in), .dl_link_in(dl_link_in),
    .ext_overhead_in(ext_overhead_in));
  // gather line bits frame by frame; keep the link byte of each frame
  always @(posedge clk) begin
    if (sys_data_req) sq.push_back(sys_data_in);
    if (dl_link_req) dbyte <= {dbyte[6:0], dl_link_in};
    if (line_frame_start) begin
      if (pos > 0) begin
        fp = fr;
        fr = cur;
        dprev = dbyte;
        nf++;
      end
      cur[0] = line_data;
      pos = 1;
    end else if (line_bit_en && pos > 0 && pos < 4296) cur[pos++] = line_data;
    if (++cyc == 95000) begin
      n_errors++;
      give_verdict();
    end
  end
  function automatic logic [7:0] oct(input int k);
    for (int i = 0; i < 8; i++) oct[7 - i] = fr[k * 8 + i];
  endfunction : oct
  // even parity of each bit lane over the frame before the last
  function automatic logic [7:0] bip();
    bip = 8'h00;
    for (int i = 0; i < 4296; i++) bip[7 - i % 8] ^= fp[i];
  endfunction : bip
  // lfsr step for the random field values, seeded with 71
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    lfsr = {v[6:0], ^(v & 8'hb8)};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    {read, write, address, writedata} <= {!w, w, a, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    {read, write} <= 2'b00;
  endtask : bus
  // check frame n once it is complete; dat means all bits came from data
  task automatic frm(input int n, input logic dat, ss,
                     input logic [7:0] tr, ma, nr, gc, input logic [8:0] fl);
    int bad;
    logic [7:0] o;
    bad = 0;
    wait (nf == n + 1);
    o = oct(178);
    mi = o[2:1];
    chk("fa1", dat ? 8'h00 : e3_ovh_pkg::FA1_PATTERN, oct(0));
    chk("fa2", dat ? 8'h00 : e3_ovh_pkg::FA2_PATTERN, oct(1));
    chk("em", dat ? 8'h00 : bip(), oct(60));
    chk("tr", tr, oct(119));
    chk("ma", ss ? {ma[7:3], mi, fl[8 - mi]} : ma, o);
    chk("nr", ss ? dprev : nr, oct(237));
    chk("gc", gc, oct(296));
    for (int i = 0; i < 4296 && !dat; i++)
      if (!(i / 8 inside {0, 1, 60, 119, 178, 237, 296}))
        bad += (fr[i] !== sq.pop_front());
    chk("payload", 8'h00, (bad > 0) ? 8'h01 : 8'h00);
    $display("test frame %0d done", n);
  endtask : frm
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    logic [31:0] q;
    logic [8:0] f1, f2;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 8'h00, q[7:0]);
    wait (nf == 0 && pos > 2600);
    lf = lfsr(lf);
    f1 = {lf[0], lf};
    bus(1'b1, 4'h4, {23'h0, f1}, q);
    bus(1'b0, 4'h4, 32'h0, q);
    chk("field read", f1[7:0], q[7:0]);
    bus(1'b1, 4'h0, 32'h0000010c, q);  // auto rdi, pin trace, nr from pin
    {rx_los, rx_bip_err_tgl} <= 2'b11;
    frm(0, 0, 0, 8'h00, 8'h00, 8'hff, 8'hff, 9'h0);
    wait (nf == 1 && pos > 2600);
    lf = lfsr(lf);
    f2 = {lf[3], lf};
    bus(1'b1, 4'h4, {23'h0, f2}, q);
    bus(1'b1, 4'h0, 32'h000014a0, q);  // forced rdi, pin rei, status, lapd
    rx_los <= 1'b0;
    frm(1, 0, 0, 8'hff, {2'b11, f1[2:0], f1[4:3], f1[8]}, 8'hff, 8'hff, f1);
    frm(2, 0, 1, 8'h00, {2'b11, f2[2:0], 3'h0}, 8'h00, 8'hff, f2);
    chk("mi clear", 8'h01, {6'h00, mi});
    wait (nf == 3 && pos > 2600);
    bus(1'b1, 4'h0, 32'h00000001, q);  // alarm cleared, all from data
    sys_zero <= 1'b1;
    frm(3, 0, 1, 8'h00, {2'b11, f2[2:0], 3'h0}, 8'h00, 8'hff, f2);
    chk("mi step", 8'h02, {6'h00, mi});
    frm(4, 1, 0, 8'h00, 8'h00, 8'h00, 8'h00, 9'h0);
    bus(1'b1, 4'h0, 32'h00000801, q);  // ais on top of all-zero data
    repeat (2) @(posedge clk iff line_bit_en);
    chk("ais", 8'h01, {7'h00, line_data});
    $display("test ais done");
    give_verdict();
  end
endmodule : e3_g832_tx_overhead_insert_test
